// ---- src/pwm_timer_pkg.sv ----
// Constants, field layout and types of the two-channel PWM timer.
// Assumes a Wishbone slave with 32-bit data and byte addressing.
// Summary of operation
// - Width follows channel value in modulo+1 steps; 0x0080 is half duty at modulo 0x00FF.
// - Unbuffered PWM: a value write takes effect at once on any channel.
// - Channel flag rises at pulse end, overflow flag at period end.
// - Buffered select in channel 0 control links both channels onto pin 0.
// - Buffered starts on channel 0; channel 1 write wins next period.
// - Each buffered overflow selects the value written most recently.
// - Buffered: channel 0 control governs, channel 1 idle, pin 1 freed.
// - Overflow flag sets at modulo; requests only with overflow enable.
// - Channel flag sets on capture or compare; requests when enabled.
// - In wait the counter runs, registers close, enabled requests wake.
// - In stop the counter halts and registers close; captures still load values and flags; reset resets it.
// - A break stops the counter.
// - With break clear enable set, flags clear in break and stay cleared.
// - With break clear enable clear, bus access in break spares flags.
// - A clear step begun before a protected break completes after it.
package pwm_timer_pkg;
    localparam logic [7:0]  CNT_CTL_OFS = 8'h00;
    localparam logic [7:0]  CNT_VAL_OFS = 8'h04;
    localparam logic [7:0]  MOD_OFS     = 8'h08;
    localparam logic [7:0]  BRK_CTL_OFS = 8'h1C;
    localparam logic [7:0]  CH_CTL_OFS [2] = '{8'h0C, 8'h14};
    localparam logic [7:0]  CH_VAL_OFS [2] = '{8'h10, 8'h18};
    localparam int          FLAG_BIT  = 7;
    localparam int          IE_BIT    = 6;
    localparam int          STOP_BIT  = 5;
    localparam int          CRST_BIT  = 4;
    localparam int          BUF_BIT   = 5;
    localparam int          CMPEN_BIT = 4;
    localparam int          ACT_LSB   = 2;
    localparam int          OVS_BIT   = 1;
    localparam int          BRK_CLR_BIT = 0;
    localparam logic [15:0] MOD_RST   = 16'hFFFF;
    localparam logic [15:0] VAL_RST   = 16'h0000;
    // Compare action; in capture mode the same codes pick the edge
    typedef enum logic [1:0] {
        ACT_NONE   = 2'b00,
        ACT_TOGGLE = 2'b01,
        ACT_CLEAR  = 2'b10,
        ACT_SET    = 2'b11
    } act_t;
endpackage : pwm_timer_pkg

// ---- src/chan_if.sv ----
// Carrier between the timer top and one channel unit.
// Assumes both sides run on the same clock.
`timescale 1ns/1ns
interface chan_if;
    import pwm_timer_pkg::*;
    logic        cmp_en;
    act_t        act;
    logic        ovf_set;
    logic [15:0] val;
    logic [15:0] nxt;
    logic        tick;
    logic        ovf;
    logic        pin_s;
    logic        match;
    logic        capt;
    logic        out;
    logic        drive;
    modport ctrl (output cmp_en, act, ovf_set, val, nxt, tick, ovf, pin_s,
                  input match, capt, out, drive);
    modport unit (input cmp_en, act, ovf_set, val, nxt, tick, ovf, pin_s,
                  output match, capt, out, drive);
endinterface : chan_if

// ---- src/tim_counter.sv ----
// Free-running up counter with modulo wrap.
// Assumes run_i and clr_i come from logic on the same clock.
`timescale 1ns/1ns
module period_counter
    import pwm_timer_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic        clr_i,
    input  wire logic [15:0] modulo_i,
    output logic      [15:0] cnt_o,
    output logic      [15:0] nxt_o,
    output logic             tick_o,
    output logic             ovf_o
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    // Next count; the wrap at modulo marks the end of a period
    always_comb begin
        nxt_o  = (cnt_q == modulo_i) ? 16'h0000 : cnt_q + 16'h0001;
        tick_o = run_i;
        ovf_o  = run_i && (cnt_q == modulo_i);
        cnt_d  = cnt_q;
        if (clr_i) begin
            cnt_d = 16'h0000;
        end else if (run_i) begin
            cnt_d = nxt_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= VAL_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign cnt_o = cnt_q;
endmodule : period_counter

// ---- src/chan_unit.sv ----
// One compare/capture channel with its pin output level.
// Assumes pin_s is already synchronised to clk_i.
`timescale 1ns/1ns
module chan_unit
    import pwm_timer_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    chan_if.unit      ch
);
    logic out_q;
    logic out_d;
    logic prev_q;
    logic rise;
    logic fall;

    // Compare looks at the count being entered, so value 0 gives 0% duty
    always_comb begin
        ch.match = ch.tick && ch.cmp_en && (ch.nxt == ch.val);
        rise     = ch.pin_s && !prev_q;
        fall     = !ch.pin_s && prev_q;
        ch.capt  = !ch.cmp_en && (((ch.act == ACT_TOGGLE) && rise) ||
                   ((ch.act == ACT_CLEAR) && fall) ||
                   ((ch.act == ACT_SET) && (rise || fall)));
        ch.drive = ch.cmp_en && (ch.act != ACT_NONE);
        out_d    = out_q;
        if (ch.match) begin
            case (ch.act)
                ACT_TOGGLE: out_d = !out_q;
                ACT_CLEAR:  out_d = 1'b0;
                ACT_SET:    out_d = 1'b1;
                default:    out_d = out_q;
            endcase
        end else if (ch.ovf && ch.ovf_set && ch.cmp_en) begin
            case (ch.act)
                ACT_CLEAR: out_d = 1'b1;
                ACT_SET:   out_d = 1'b0;
                default:   out_d = out_q;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q  <= 1'b0;
            prev_q <= 1'b1; // Idle pin is high; 0 would fake a rise
        end else begin
            out_q  <= out_d;
            prev_q <= ch.pin_s;
        end
    end

    assign ch.out = out_q;
endmodule : chan_unit

// ---- src/pwm_timer.sv ----
// Top of the two-channel PWM timer with its Wishbone register file.
// Assumes break, wait and stop levels come from system logic on clk_i;
// pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
module pwm_timer
    import pwm_timer_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        break_i,
    input  wire logic        wait_i,
    input  wire logic        stop_i,
    input  wire logic [1:0]  ch_pin_i,
    output logic      [1:0]  ch_pin_o,
    output logic      [1:0]  ch_pin_oe_n_o,
    output logic             irq_o
);
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction : merge16

    logic        ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic        irq_q, irq_d;
    logic        ovf_flag_q, ovf_flag_d, ovf_ie_q, ovf_ie_d;
    logic        ovf_arm_q, ovf_arm_d, stop_q, stop_d;
    logic [15:0] mod_q, mod_d;
    logic        brk_clr_q, brk_clr_d;
    logic        bufsel_q, bufsel_d, act_sel_q, act_sel_d;
    logic        last_wr_q, last_wr_d;
    logic [1:0]  flag_q, flag_d, ie_q, ie_d, arm_q, arm_d;
    logic [1:0]  cmp_en_q, cmp_en_d, ovs_q, ovs_d;
    act_t        act_q [2];
    act_t        act_d [2];
    logic [15:0] val_q [2];
    logic [15:0] val_d [2];
    logic [1:0]  pin_s1_q, pin_s2_q, oe_n_q, oe_n_d;
    logic        req, wr_fire, acc_ok, clr_ok, cnt_clr, run;
    logic [15:0] cnt, nxt;
    logic        tick, ovf;
    logic [31:0] rd;
    logic [1:0]  ch_match, ch_capt;

    chan_if chif [2] ();

    // Break and stop freeze the count; wait leaves it running
    assign run = !stop_q && !break_i && !stop_i;

    period_counter u_cnt (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .run_i    (run),
        .clr_i    (cnt_clr),
        .modulo_i (mod_q),
        .cnt_o    (cnt),
        .nxt_o    (nxt),
        .tick_o   (tick),
        .ovf_o    (ovf)
    );

    // Channel 1 is muted while linked so its pin is free for other use
    for (genvar g = 0; g < 2; g++) begin : g_ch
        if (g == 0) begin : g_c0
            assign chif[g].val = (bufsel_q && act_sel_q) ? val_q[1]
                                                         : val_q[0];
            assign chif[g].cmp_en = cmp_en_q[g];
            assign chif[g].act    = act_q[g];
        end else begin : g_c1
            assign chif[g].val    = val_q[g];
            assign chif[g].cmp_en = cmp_en_q[g] && !bufsel_q;
            assign chif[g].act    = bufsel_q ? ACT_NONE : act_q[g];
        end
        assign chif[g].ovf_set = ovs_q[g];
        assign chif[g].nxt     = nxt;
        assign chif[g].tick    = tick;
        assign chif[g].ovf     = ovf;
        assign chif[g].pin_s   = pin_s2_q[g];
        chan_unit u_ch (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .ch    (chif[g])
        );
        assign ch_pin_o[g] = chif[g].out;
        // Plain vectors, since an interface array takes no loop index
        assign ch_match[g] = chif[g].match;
        assign ch_capt[g]  = chif[g].capt;
    end

    // Bus qualifiers; flags are guarded while a protected break holds
    always_comb begin
        req     = cyc_i && stb_i;
        acc_ok  = !wait_i && !stop_i;
        clr_ok  = !break_i || brk_clr_q;
        wr_fire = req && we_i && ack_q && acc_ok;
        cnt_clr = wr_fire && sel_i[0] && (adr_i == CNT_CTL_OFS) &&
                  dat_i[CRST_BIT];
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd = 32'h0000_0000;
        case (adr_i)
            CNT_CTL_OFS: rd[7:5] = {ovf_flag_q, ovf_ie_q, stop_q};
            CNT_VAL_OFS: rd[15:0] = cnt;
            MOD_OFS:     rd[15:0] = mod_q;
            BRK_CTL_OFS: rd[BRK_CLR_BIT] = brk_clr_q;
            CH_VAL_OFS[0]: rd[15:0] = val_q[0];
            CH_VAL_OFS[1]: rd[15:0] = val_q[1];
            CH_CTL_OFS[0]: rd[7:1] = {flag_q[0], ie_q[0], bufsel_q,
                                      cmp_en_q[0], act_q[0], ovs_q[0]};
            CH_CTL_OFS[1]: rd[7:1] = {flag_q[1], ie_q[1], 1'b0,
                                      cmp_en_q[1], act_q[1], ovs_q[1]};
            default:     rd = 32'h0000_0000;
        endcase
    end

    // Bus answer, counter controls and overflow flag
    always_comb begin
        ack_d      = req && !ack_q;
        dat_d      = (ack_d && !we_i && acc_ok) ? rd : 32'h0000_0000;
        ovf_flag_d = ovf_flag_q;
        ovf_arm_d  = ovf_arm_q;
        ovf_ie_d   = ovf_ie_q;
        stop_d     = stop_q;
        mod_d      = mod_q;
        brk_clr_d  = brk_clr_q;
        // First clearing step: reading the flag while it is set
        if (ack_d && !we_i && acc_ok && clr_ok &&
            adr_i == CNT_CTL_OFS && ovf_flag_q) begin
            ovf_arm_d = 1'b1;
        end
        if (wr_fire && sel_i[0] && adr_i == CNT_CTL_OFS) begin
            ovf_ie_d = dat_i[IE_BIT];
            stop_d   = dat_i[STOP_BIT];
            if (clr_ok) begin
                if (ovf_arm_q && !dat_i[FLAG_BIT]) begin
                    ovf_flag_d = 1'b0;
                end
                ovf_arm_d = 1'b0;
            end
        end
        if (wr_fire && adr_i == MOD_OFS) begin
            mod_d = merge16(mod_q, dat_i, sel_i);
        end
        if (wr_fire && sel_i[0] && adr_i == BRK_CTL_OFS) begin
            brk_clr_d = dat_i[BRK_CLR_BIT];
        end
        if (ovf) begin
            ovf_flag_d = 1'b1;
        end
        irq_d = (ovf_flag_q && ovf_ie_q) ||
                |(flag_q & ie_q);
    end

    // Channel registers, flags and the buffered pair selection
    always_comb begin
        bufsel_d  = bufsel_q;
        act_sel_d = act_sel_q;
        last_wr_d = last_wr_q;
        for (int i = 0; i < 2; i++) begin
            flag_d[i]   = flag_q[i];
            ie_d[i]     = ie_q[i];
            arm_d[i]    = arm_q[i];
            cmp_en_d[i] = cmp_en_q[i];
            ovs_d[i]    = ovs_q[i];
            act_d[i]    = act_q[i];
            val_d[i]    = val_q[i];
            if (ack_d && !we_i && acc_ok && clr_ok &&
                adr_i == CH_CTL_OFS[i] && flag_q[i]) begin
                arm_d[i] = 1'b1;
            end
            if (wr_fire && sel_i[0] && adr_i == CH_CTL_OFS[i]) begin
                ie_d[i]     = dat_i[IE_BIT];
                cmp_en_d[i] = dat_i[CMPEN_BIT];
                ovs_d[i]    = dat_i[OVS_BIT];
                act_d[i]    = act_t'(dat_i[ACT_LSB +: 2]);
                if (clr_ok) begin
                    if (arm_q[i] && !dat_i[FLAG_BIT]) begin
                        flag_d[i] = 1'b0;
                    end
                    arm_d[i] = 1'b0;
                end
            end
            if (wr_fire && adr_i == CH_VAL_OFS[i]) begin
                val_d[i] = merge16(val_q[i], dat_i, sel_i);
                last_wr_d = (i == 1);
            end
            if (ch_capt[i]) begin
                val_d[i] = cnt;
            end
            if (ch_match[i] || ch_capt[i]) begin
                flag_d[i] = 1'b1;
            end
        end
        if (wr_fire && sel_i[0] && adr_i == CH_CTL_OFS[0]) begin
            bufsel_d = dat_i[BUF_BIT];
            if (dat_i[BUF_BIT] && !bufsel_q) begin
                act_sel_d = 1'b0;
                last_wr_d = 1'b0;
            end
        end
        if (bufsel_q && ovf) begin
            act_sel_d = last_wr_d;
        end
        oe_n_d[0] = !chif[0].drive;
        oe_n_d[1] = !chif[1].drive || bufsel_q;
    end

    // Register stage; pins pass two flip-flops before any use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q      <= 1'b0;
            dat_q      <= 32'h0000_0000;
            irq_q      <= 1'b0;
            ovf_flag_q <= 1'b0;
            ovf_ie_q   <= 1'b0;
            ovf_arm_q  <= 1'b0;
            stop_q     <= 1'b0;
            mod_q      <= MOD_RST;
            brk_clr_q  <= 1'b0;
            bufsel_q   <= 1'b0;
            act_sel_q  <= 1'b0;
            last_wr_q  <= 1'b0;
            flag_q     <= 2'h0;
            ie_q       <= 2'h0;
            arm_q      <= 2'h0;
            cmp_en_q   <= 2'h0;
            ovs_q      <= 2'h0;
            act_q      <= '{ACT_NONE, ACT_NONE};
            val_q      <= '{VAL_RST, VAL_RST};
            pin_s1_q   <= 2'h3; // Idle pin level, no false edge
            pin_s2_q   <= 2'h3;
            oe_n_q     <= 2'h3;
        end else begin
            ack_q      <= ack_d;
            dat_q      <= dat_d;
            irq_q      <= irq_d;
            ovf_flag_q <= ovf_flag_d;
            ovf_ie_q   <= ovf_ie_d;
            ovf_arm_q  <= ovf_arm_d;
            stop_q     <= stop_d;
            mod_q      <= mod_d;
            brk_clr_q  <= brk_clr_d;
            bufsel_q   <= bufsel_d;
            act_sel_q  <= act_sel_d;
            last_wr_q  <= last_wr_d;
            flag_q     <= flag_d;
            ie_q       <= ie_d;
            arm_q      <= arm_d;
            cmp_en_q   <= cmp_en_d;
            ovs_q      <= ovs_d;
            act_q      <= act_d;
            val_q      <= val_d;
            pin_s1_q   <= ch_pin_i;
            pin_s2_q   <= pin_s1_q;
            oe_n_q     <= oe_n_d;
        end
    end

    assign ack_o         = ack_q;
    assign dat_o         = dat_q;
    assign irq_o         = irq_q;
    assign ch_pin_oe_n_o = oe_n_q;

    // Checks on the behaviour above
    ovf_flag_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovf |=> ovf_flag_q) else $error("overflow flag missed");
    ovf_irq_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovf_flag_q && !ovf_ie_q && !(|(flag_q & ie_q)) |=> !irq_q)
        else $error("overflow request not masked");
    // Request is one cycle behind the flag, gated by the enable of then
    ch_flag_set_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ch_match[0] |=> flag_q[0] ##1 (irq_q || !$past(ie_q[0])))
        else $error("channel flag or request missed");
    brk_freeze_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        break_i && !cnt_clr |=> cnt == $past(cnt))
        else $error("counter moved in break");
    stop_freeze_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        stop_i [*2] |-> $stable(cnt))
        else $error("counter moved in stop");
    brk_protect_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        break_i && !brk_clr_q && ovf_flag_q |=> ovf_flag_q)
        else $error("flag cleared in protected break");
    buf_select_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        bufsel_q && ovf && !wr_fire |=> act_sel_q == $past(last_wr_q))
        else $error("wrong buffered value chosen");
    pin1_release_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        bufsel_q |=> ch_pin_oe_n_o[1])
        else $error("pin 1 driven in buffered mode");
    pwm_fall_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ch_match[0] && act_q[0] == ACT_CLEAR |=> !ch_pin_o[0])
        else $error("output not cleared at compare");
    wait_lock_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wait_i && !ovf |=> $stable(ovf_ie_q) && $stable(mod_q))
        else $error("register changed in wait");
endmodule : pwm_timer

// ---- dv/pin_load.sv ----
// External load on both timer pins: pull-ups and a pulse meter on pin 0.
// Assumes the timer changes its pin levels only on rising clk_i edges.
`timescale 1ns/1ns
module pin_load (
    input  wire logic       clk_i,
    input  wire logic [1:0] pin_i,
    input  wire logic [1:0] oe_n_i,
    output logic      [1:0] line_o,
    output int              hi_o,
    output int              per_o
);
    int   hi_q;
    int   per_q;
    logic prev_q;

    // A released pin floats up to the pull-up level, never the last value
    assign line_o = pin_i | oe_n_i;

    // Width and period are latched at each rising edge of the pin 0 line
    always @(posedge clk_i) begin
        prev_q <= line_o[0];
        if (line_o[0] && !prev_q) begin
            hi_o  <= hi_q;
            per_o <= per_q;
            hi_q  <= 1;
            per_q <= 1;
        end else begin
            hi_q  <= hi_q + int'(line_o[0]);
            per_q <= per_q + 1;
        end
    end
endmodule : pin_load

// ---- dv/timer_pwm_irq_lowpower_tb.sv ----
// Self-checking bench of the PWM timer through its Wishbone registers.
// Assumes the pin_load model closes the pins; all inputs move after edges.
`timescale 1ns/1ns
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin \
    err_total++; $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); \
    end end
module timer_pwm_irq_lowpower_tb
    import pwm_timer_pkg::*;
;
    logic        clk_i;
    logic        rst_i;
    logic [7:0]  adr_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic        we_i;
    logic [3:0]  sel_i;
    logic        cyc_i;
    logic        stb_i;
    logic        ack_o;
    logic        break_i;
    logic        wait_i;
    logic        stop_i;
    logic [1:0]  line;
    logic [1:0]  pin_o;
    logic [1:0]  oe_n;
    logic        irq_o;
    int          hi;
    int          per;
    int          err_total;
    int          n_compared;
    int          n;
    logic [31:0] d;
    logic [31:0] a_v;

    pwm_timer dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i),
        .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .break_i(break_i),
        .wait_i(wait_i), .stop_i(stop_i), .ch_pin_i(line),
        .ch_pin_o(pin_o), .ch_pin_oe_n_o(oe_n), .irq_o(irq_o));

    pin_load load (.clk_i(clk_i), .pin_i(pin_o), .oe_n_i(oe_n),
        .line_o(line), .hi_o(hi), .per_o(per));

    // 100 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // One classic cycle; entered just after an edge, leaves one idle cycle.
    // Waits for ack as long as it takes; only the watchdog ends a hang.
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        adr_i <= a;
        we_i  <= w;
        dat_i <= wd;
        sel_i <= 4'hF;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] dummy;
        xfer(a, 1'b1, wd, dummy);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] rv);
        xfer(a, 1'b0, 32'h0, rv);
    endtask : rd

    // Wait for pin 0 to reach lvl from the other level, bounded
    task automatic wait_line(input logic lvl);
        int k;
        k = 0;
        while (line[0] !== ~lvl && k < 600) begin
            @(posedge clk_i);
            k++;
        end
        while (line[0] !== lvl && k < 1200) begin
            @(posedge clk_i);
            k++;
        end
        if (k >= 1200) err_total++;
    endtask : wait_line

    // Two-step flag clear around a break; counter restarted to keep
    // an overflow from landing inside the sequence
    task automatic brk_seq(input logic clr_en);
        logic [31:0] c1;
        logic [31:0] c2;
        logic [31:0] r;
        wr(BRK_CTL_OFS, {31'h0, clr_en});
        wait_line(1'b1);
        wr(CNT_CTL_OFS, 32'h10);
        rd(CNT_CTL_OFS, r);
        break_i <= 1'b1;
        rd(CNT_VAL_OFS, c1);
        repeat (20) @(posedge clk_i);
        rd(CNT_VAL_OFS, c2);
        `CHK(c2, c1)
        wr(CNT_CTL_OFS, 32'h0);
        rd(CNT_CTL_OFS, r);
        `CHK(r[7], ~clr_en)
        break_i <= 1'b0;
        wr(CNT_CTL_OFS, 32'h0);
        rd(CNT_CTL_OFS, r);
        `CHK(r[7], 1'b0)
    endtask : brk_seq

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // Hang guard, well beyond the roughly 5000 cycles the tests need
    initial begin
        repeat (30000) @(posedge clk_i);
        err_total++;
        report_and_stop();
    end

    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, break_i, wait_i, stop_i} = 6'h00;
        adr_i = 8'h00;
        dat_i = 32'h0;
        sel_i = 4'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Reset state and an unmapped place
        rd(MOD_OFS, d);
        `CHK(d, 32'h0000FFFF)
        rd(CH_VAL_OFS[0], d);
        `CHK(d, 32'h0)
        `CHK(oe_n, 2'b11)
        wr(8'h20, 32'hFF);
        rd(8'h20, d);
        `CHK(d, 32'h0)
        // 256-step PWM, clear on compare and set at overflow, irq enabled
        wr(MOD_OFS, 32'hFF);
        wr(CH_VAL_OFS[0], 32'h80);
        wr(CH_CTL_OFS[0], 32'h5A);
        repeat (600) @(posedge clk_i);
        `CHK(hi, 128)
        `CHK(per, 256)
        wait_line(1'b0);
        wr(CH_VAL_OFS[0], 32'h40);
        repeat (600) @(posedge clk_i);
        `CHK(hi, 64)
        `CHK(irq_o, 1'b1)
        // Channel flag: cleared early in the period, set at pulse end
        wait_line(1'b1);
        rd(CH_CTL_OFS[0], d);
        wr(CH_CTL_OFS[0], 32'h1A);
        rd(CH_CTL_OFS[0], d);
        `CHK(d[7], 1'b0)
        wait_line(1'b0);
        rd(CH_CTL_OFS[0], d);
        `CHK(d[7], 1'b1)
        // Overflow flag and its enable
        rd(CNT_CTL_OFS, d);
        wr(CNT_CTL_OFS, 32'h40);
        rd(CNT_CTL_OFS, d);
        `CHK(d[7], 1'b0)
        `CHK(irq_o, 1'b0)
        wait_line(1'b1);
        rd(CNT_CTL_OFS, d);
        `CHK(d[7], 1'b1)
        `CHK(irq_o, 1'b1)
        wr(CNT_CTL_OFS, 32'h0);
        wait_line(1'b1);
        `CHK(irq_o, 1'b0)
        brk_seq(1'b0);
        brk_seq(1'b1);
        wr(BRK_CTL_OFS, 32'h0);
        // Wait mode: counter runs, registers closed, request wakes
        wr(CNT_CTL_OFS, 32'h50);
        wait_i <= 1'b1;
        wr(MOD_OFS, 32'h10);
        rd(CNT_CTL_OFS, d);
        `CHK(d, 32'h0)
        for (n = 0; n < 600 && irq_o !== 1'b1; n++) @(posedge clk_i);
        `CHK(irq_o, 1'b1)
        wait_i <= 1'b0;
        // Stop mode: counter halts, registers kept
        wr(CNT_CTL_OFS, 32'h10);
        rd(CNT_VAL_OFS, a_v);
        stop_i <= 1'b1;
        repeat (100) @(posedge clk_i);
        stop_i <= 1'b0;
        rd(CNT_VAL_OFS, d);
        `CHK((d - a_v) < 32'h10, 1'b1)
        rd(MOD_OFS, d);
        `CHK(d, 32'h000000FF)
        // Stop bit freezes the count like the stop level does
        wr(CNT_CTL_OFS, 32'h20);
        rd(CNT_VAL_OFS, a_v);
        repeat (20) @(posedge clk_i);
        rd(CNT_VAL_OFS, d);
        `CHK(d, a_v)
        wr(CNT_CTL_OFS, 32'h0);
        // Buffered pair; channel 1 control set first, it must lose the pin
        wr(CH_VAL_OFS[0], 32'h40);
        wr(CH_CTL_OFS[1], 32'h1A);
        wr(CH_CTL_OFS[0], 32'h3A);
        repeat (3) @(posedge clk_i);
        `CHK(oe_n, 2'b10)
        `CHK(line[1], 1'b1)
        repeat (600) @(posedge clk_i);
        `CHK(hi, 64)
        wr(CH_VAL_OFS[1], 32'h20);
        repeat (600) @(posedge clk_i);
        `CHK(hi, 32)
        wr(CH_VAL_OFS[0], 32'h60);
        repeat (600) @(posedge clk_i);
        `CHK(hi, 96)
        // Unlink; channel 1 takes its pin back and settles low, then
        // switches to rising-edge capture and releases the pin, which
        // the pull-up lifts. Value above modulo keeps compares away.
        wr(CH_CTL_OFS[0], 32'h1A);
        wr(CH_CTL_OFS[1], 32'h18);
        repeat (300) @(posedge clk_i);
        `CHK(line[1], 1'b0)
        wr(CH_VAL_OFS[1], 32'h1FF);
        rd(CH_CTL_OFS[1], d);
        wr(CH_CTL_OFS[1], 32'h04);
        rd(CH_CTL_OFS[1], d);
        `CHK(d[7], 1'b0)
        repeat (4) @(posedge clk_i);
        rd(CH_CTL_OFS[1], d);
        `CHK(d[7], 1'b1)
        rd(CH_VAL_OFS[1], d);
        `CHK(d[15:0] <= 16'h00FF, 1'b1)
        report_and_stop();
    end
endmodule : timer_pwm_irq_lowpower_tb
